//--- core/gmp_pkg.sv
// Constants, field layouts and carrier types for the gripper Modbus status port
package gmp_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ         = 125_000_000;
  localparam int REFRESH_HZ     = 200;
  localparam int REFRESH_CYCLES = CLK_HZ / REFRESH_HZ;

  // ****************************************
  // Function codes and unit identifiers
  // ****************************************
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_READ_INPUT   = 8'h04;
  localparam logic [7:0] FC_WRITE_MULTI  = 8'h10;
  localparam logic [7:0] TCP_UNIT_ID     = 8'h02;
  localparam logic [7:0] RTU_SLAVE_ID    = 8'h09;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] REG_GRIPPER_STATUS_WORD     = 16'h07d0;
  localparam logic [15:0] REG_FAULT_AND_POSITION_ECHO = 16'h07d1;
  localparam logic [15:0] REG_POSITION_AND_CURRENT    = 16'h07d2;
  localparam logic [15:0] RTU_STAT_BASE               = REG_GRIPPER_STATUS_WORD;
  localparam logic [15:0] RTU_CMD_BASE                = 16'h03e8;
  localparam logic [15:0] TCP_STAT_BASE               = 16'h0000;
  localparam logic [15:0] TCP_CMD_BASE                = 16'h0000;
  localparam int          MAP_WORDS                   = 8;
  localparam int          MAP_BYTES                   = 2 * MAP_WORDS;

  // Internal byte indices, word w = {byte 2w, byte 2w+1}
  localparam int SB_STATUS   = 0;
  localparam int SB_RESERVED = 1;
  localparam int SB_FAULT    = 2;
  localparam int SB_ECHO     = 3;
  localparam int SB_POSITION = 4;
  localparam int SB_CURRENT  = 5;
  localparam int CB_ACTION   = 0;
  localparam int CB_OPTIONS  = 1;
  localparam int CB_OPTIONS2 = 2;
  localparam int CB_POS_REQ  = 3;
  localparam int CB_SPEED    = 4;
  localparam int CB_FORCE    = 5;

  // ****************************************
  // Status byte fields
  // ****************************************
  localparam int         ACT_BIT       = 0;
  localparam int         GOTO_BIT      = 3;
  localparam int         STA_LSB       = 4;
  localparam int         OBJ_LSB       = 6;
  localparam logic [7:0] RESERVED_BYTE = 8'h00;
  localparam logic [1:0] OBJ_MOVING    = 2'h0;
  localparam logic [1:0] OBJ_AT_POS    = 2'h3;
  localparam logic [7:0] SOFT_OPEN_LIMIT      = 8'h0d;
  localparam int         CURRENT_MA_PER_COUNT = 10;

  // ****************************************
  // Framing
  // ****************************************
  localparam logic [7:0]  TCP_HDR_LEN  = 8'h06;
  localparam logic [7:0]  PDU_DATA_OFS = 8'h07;
  localparam logic [7:0]  CRC_LEN      = 8'h02;
  localparam logic [7:0]  RD_REQ_PDU   = 8'h06;
  localparam logic [7:0]  WR_RESP_PDU  = 8'h06;
  localparam logic [7:0]  RD_RESP_FIX  = 8'h03;
  localparam logic [15:0] TCP_PROTO_ID = 16'h0000;
  localparam logic [15:0] CRC_INIT     = 16'hffff;
  localparam logic [15:0] CRC_POLY     = 16'ha001;

  typedef struct packed {
    logic       activation_flag;
    logic       goto_active_flag;
    logic [1:0] motion_state;
    logic [1:0] object_detect_field;
    logic [7:0] fault;
    logic [7:0] position;
    logic [7:0] current;
  } gmp_core_status_s;

  typedef struct packed {
    logic [7:0] action;
    logic [7:0] options;
    logic [7:0] options2;
    logic [7:0] pos_req;
    logic [7:0] speed;
    logic [7:0] force_req;
  } gmp_cmd_s;

  typedef enum logic [0:0] {
    GMP_IDLE,
    GMP_SEND
  } gmp_state_e;

endpackage

//--- core/gmp_crc16.sv
// Reflected 16-bit frame check accumulator, one byte per cycle
`timescale 1ns/1ps
module gmp_crc16 (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clear,
  input  wire logic        valid,
  input  wire logic [7:0]  data,
  output logic      [15:0] crc_q,
  output logic      [15:0] crc_next
);
  import gmp_pkg::*;

  always_comb begin
    logic [15:0] c;
    c = crc_q ^ {8'h00, data};
    for (int b = 0; b < 8; b++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    crc_next = c;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_q <= CRC_INIT;
    end else if (clear) begin
      crc_q <= CRC_INIT;
    end else if (valid) begin
      crc_q <= crc_next;
    end
  end
endmodule

//--- core/gmp_modbus_port.sv
// Modbus request interpreter and status word server of the gripper
`timescale 1ns/1ps
module gmp_modbus_port #(
  parameter int REFRESH_CYCLES_P = gmp_pkg::REFRESH_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      rtu_mode,
  input  wire logic                      session_open,
  input  wire logic                      rx_valid,
  input  wire logic [7:0]                rx_byte,
  input  wire logic                      rx_end,
  input  wire logic                      tx_ready,
  input  wire gmp_pkg::gmp_core_status_s core_status,
  output logic                           tx_valid_q,
  output logic      [7:0]                tx_byte_q,
  output logic                           tx_last_q,
  output gmp_pkg::gmp_cmd_s              cmd_q,
  output logic      [7:0]                target_pos_q,
  output logic                           motion_stop_q,
  output logic                           crc_error_q,
  output logic                           req_done_q
);
  import gmp_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  gmp_state_e  state_q;
  logic [7:0]  idx_q;
  logic [15:0] tid_q;
  logic [15:0] pid_q;
  logic [15:0] len_q;
  logic [7:0]  unit_q;
  logic [7:0]  fc_q;
  logic [15:0] addr_q;
  logic [15:0] cnt_q;
  logic [7:0]  bc_q;
  logic [7:0]  stat_q  [MAP_BYTES];
  logic [7:0]  cmem_q  [MAP_BYTES];
  logic [7:0]  stage_q [MAP_BYTES];
  logic [7:0]  tx_idx_q;
  logic [7:0]  resp_len_q;
  logic [31:0] refresh_cnt_q;
  logic        refresh_pend_q;
  logic [15:0] rx_crc_q;
  logic [15:0] tx_crc_q;
  logic [15:0] tx_crc_next;
  logic [7:0]  hdr;
  logic [7:0]  pos;
  logic        is_wr;
  logic [15:0] rel_word;
  logic [16:0] word_end;
  logic [8:0]  rel_byte;
  logic        range_ok;
  logic        accept;
  logic [7:0]  body_len;
  logic [7:0]  resp_len;
  logic [7:0]  nidx;
  logic [7:0]  rb;
  logic        rx_take;
  logic        tx_fire;
  logic        tx_crc_feed;
  logic        refresh_tick;

  assign hdr     = rtu_mode ? 8'h00 : TCP_HDR_LEN;
  assign pos     = idx_q - hdr;
  assign is_wr   = (fc_q == FC_WRITE_MULTI);
  assign rx_take = rx_valid && (state_q == GMP_IDLE);
  assign tx_fire = tx_valid_q && tx_ready;

  // ****************************************
  // Request decode
  // ****************************************
  always_comb begin
    logic [15:0] base;
    logic [7:0]  exp_len;
    logic        unit_ok;
    logic        fc_ok;
    logic        bc_ok;
    logic        tcp_ok;
    logic        crc_ok;
    // Base selection
    base     = rtu_mode ? (is_wr ? RTU_CMD_BASE : RTU_STAT_BASE) : (is_wr ? TCP_CMD_BASE : TCP_STAT_BASE);
    rel_word = addr_q - base;
    word_end = {1'b0, rel_word} + {1'b0, cnt_q};
    rel_byte = {rel_word[7:0], 1'b0};
    range_ok = (cnt_q != 16'h0000) && (word_end <= 17'(MAP_WORDS));
    // Unit
    unit_ok  = rtu_mode ? (unit_q == RTU_SLAVE_ID) : (unit_q == TCP_UNIT_ID);
    // Function set
    fc_ok    = is_wr || (fc_q == (rtu_mode ? FC_READ_HOLDING : FC_READ_INPUT));
    bc_ok    = !is_wr || ({8'h00, bc_q} == {cnt_q[14:0], 1'b0});
    exp_len  = hdr + PDU_DATA_OFS - 8'h01 + (is_wr ? (bc_q + 8'h01) : 8'h00) + (rtu_mode ? CRC_LEN : 8'h00);
    if (!is_wr) begin
      exp_len = hdr + RD_REQ_PDU + (rtu_mode ? CRC_LEN : 8'h00);
    end
    tcp_ok   = rtu_mode || ((pid_q == TCP_PROTO_ID) && (len_q == {8'h00, idx_q - TCP_HDR_LEN}));
    // Frame
    crc_ok   = !rtu_mode || (rx_crc_q == 16'h0000);
    accept   = rx_end && (state_q == GMP_IDLE) && unit_ok && fc_ok && range_ok && bc_ok &&
               (idx_q == exp_len) && tcp_ok && crc_ok;
    // Reply sizing
    body_len = is_wr ? WR_RESP_PDU : (RD_RESP_FIX + {cnt_q[6:0], 1'b0});
    resp_len = hdr + body_len + (rtu_mode ? CRC_LEN : 8'h00);
  end

  // ****************************************
  // Request capture
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idx_q  <= 8'h00;
      tid_q  <= 16'h0000;
      pid_q  <= 16'h0000;
      len_q  <= 16'h0000;
      unit_q <= 8'h00;
      fc_q   <= 8'h00;
      addr_q <= 16'h0000;
      cnt_q  <= 16'h0000;
      bc_q   <= 8'h00;
    end else if (rx_end) begin
      idx_q <= 8'h00;
    end else if (rx_take) begin
      // Saturate so an overlong frame can never alias a legal length
      if (idx_q != 8'hff) begin
        idx_q <= idx_q + 8'h01;
      end
      if (!rtu_mode && idx_q < TCP_HDR_LEN) begin
        case (idx_q)
          8'h00:   tid_q[15:8] <= rx_byte;
          8'h01:   tid_q[7:0]  <= rx_byte;
          8'h02:   pid_q[15:8] <= rx_byte;
          8'h03:   pid_q[7:0]  <= rx_byte;
          8'h04:   len_q[15:8] <= rx_byte;
          default: len_q[7:0]  <= rx_byte;
        endcase
      end else begin
        case (pos)
          8'h00:   unit_q       <= rx_byte;
          8'h01:   fc_q         <= rx_byte;
          8'h02:   addr_q[15:8] <= rx_byte;
          8'h03:   addr_q[7:0]  <= rx_byte;
          8'h04:   cnt_q[15:8]  <= rx_byte;
          8'h05:   cnt_q[7:0]   <= rx_byte;
          8'h06:   bc_q         <= rx_byte;
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // Write staging
  // ****************************************
  // Data is held aside so a frame that fails its checks changes nothing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int b = 0; b < MAP_BYTES; b++) begin
        stage_q[b] <= 8'h00;
      end
    end else if (rx_take && (idx_q >= hdr) && (pos >= PDU_DATA_OFS)) begin
      // Byte pairing
      for (int b = 0; b < MAP_BYTES; b++) begin
        if (((pos - PDU_DATA_OFS) < bc_q) && (rel_word < 16'(MAP_WORDS)) &&
            ((rel_byte + {1'b0, pos - PDU_DATA_OFS}) == 9'(b))) begin
          stage_q[b] <= rx_byte;
        end
      end
    end
  end

  // ****************************************
  // Command bytes and motion control
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int b = 0; b < MAP_BYTES; b++) begin
        cmem_q[b] <= 8'h00;
      end
    end else if (accept && is_wr) begin
      for (int b = 0; b < MAP_BYTES; b++) begin
        if ((9'(b) >= rel_byte) && (9'(b) < rel_byte + {cnt_q[7:0], 1'b0})) begin
          cmem_q[b] <= stage_q[b];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_q         <= '0;
      target_pos_q  <= SOFT_OPEN_LIMIT;
      motion_stop_q <= 1'b1;
      crc_error_q   <= 1'b0;
    end else begin
      cmd_q         <= {cmem_q[CB_ACTION], cmem_q[CB_OPTIONS], cmem_q[CB_OPTIONS2],
                        cmem_q[CB_POS_REQ], cmem_q[CB_SPEED], cmem_q[CB_FORCE]};
      // Opening limit
      target_pos_q  <= (cmem_q[CB_POS_REQ] < SOFT_OPEN_LIMIT) ? SOFT_OPEN_LIMIT : cmem_q[CB_POS_REQ];
      // Session loss stop
      motion_stop_q <= !rtu_mode && !session_open;
      // Bad check flag
      crc_error_q   <= rx_end && rtu_mode && (idx_q != 8'h00) && (rx_crc_q != 16'h0000);
    end
  end

  // ****************************************
  // Status refresh
  // ****************************************
  assign refresh_tick = (refresh_cnt_q == 32'(REFRESH_CYCLES_P - 1));

  // Refresh rate
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      refresh_cnt_q <= 32'h0000_0000;
    end else if (refresh_tick) begin
      refresh_cnt_q <= 32'h0000_0000;
    end else begin
      refresh_cnt_q <= refresh_cnt_q + 32'h0000_0001;
    end
  end

  // Snapshot is frozen while a reply goes out, so one reply never mixes two samples
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      refresh_pend_q <= 1'b0;
      for (int b = 0; b < MAP_BYTES; b++) begin
        stat_q[b] <= 8'h00;
      end
    end else if ((refresh_tick || refresh_pend_q) && (state_q == GMP_IDLE)) begin
      refresh_pend_q <= 1'b0;
      for (int b = 0; b < MAP_BYTES; b++) begin
        stat_q[b] <= 8'h00;
      end
      // Status byte fields
      stat_q[SB_STATUS]   <= (8'(core_status.object_detect_field) << OBJ_LSB) |
                             (8'(core_status.motion_state) << STA_LSB) |
                             (8'(core_status.goto_active_flag) << GOTO_BIT) |
                             (8'(core_status.activation_flag) << ACT_BIT);
      stat_q[SB_RESERVED] <= RESERVED_BYTE;
      // Fault and echo
      stat_q[SB_FAULT]    <= core_status.fault;
      stat_q[SB_ECHO]     <= cmem_q[CB_POS_REQ];
      // Position and current
      stat_q[SB_POSITION] <= (core_status.position < SOFT_OPEN_LIMIT) ? SOFT_OPEN_LIMIT : core_status.position;
      stat_q[SB_CURRENT]  <= core_status.current;
    end else if (refresh_tick) begin
      refresh_pend_q <= 1'b1;
    end
  end

  // ****************************************
  // Reply byte builder
  // ****************************************
  always_comb begin
    logic [7:0] rp;
    logic [8:0] sidx;
    nidx = (state_q == GMP_IDLE) ? 8'h00 : (tx_idx_q + 8'h01);
    rp   = nidx - hdr;
    sidx = rel_byte + {1'b0, rp} - 9'h003;
    rb   = 8'h00;
    if (!rtu_mode && (nidx < TCP_HDR_LEN)) begin
      case (nidx)
        8'h00:   rb = tid_q[15:8];
        8'h01:   rb = tid_q[7:0];
        8'h05:   rb = body_len;
        default: rb = 8'h00;
      endcase
    end else if (rtu_mode && (nidx >= resp_len - CRC_LEN)) begin
      // Reply check, low byte first
      rb = (nidx == resp_len - CRC_LEN) ? tx_crc_next[7:0] : tx_crc_q[15:8];
    end else begin
      // Write echo read layout
      case (rp)
        8'h00:   rb = unit_q;
        8'h01:   rb = fc_q;
        8'h02:   rb = is_wr ? addr_q[15:8] : {cnt_q[6:0], 1'b0};
        8'h03:   rb = is_wr ? addr_q[7:0] : stat_q[sidx[3:0]];
        8'h04:   rb = is_wr ? cnt_q[15:8] : stat_q[sidx[3:0]];
        8'h05:   rb = is_wr ? cnt_q[7:0] : stat_q[sidx[3:0]];
        default: rb = stat_q[sidx[3:0]];
      endcase
    end
  end

  // ****************************************
  // Reply sequencer
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= GMP_IDLE;
      tx_valid_q <= 1'b0;
      tx_byte_q  <= 8'h00;
      tx_last_q  <= 1'b0;
      tx_idx_q   <= 8'h00;
      resp_len_q <= 8'h00;
      req_done_q <= 1'b0;
    end else begin
      req_done_q <= 1'b0;
      case (state_q)
        GMP_IDLE: begin
          if (accept) begin
            state_q    <= GMP_SEND;
            tx_valid_q <= 1'b1;
            tx_byte_q  <= rb;
            tx_last_q  <= 1'b0;
            tx_idx_q   <= 8'h00;
            resp_len_q <= resp_len;
          end
        end
        GMP_SEND: begin
          if (tx_fire) begin
            if (tx_last_q) begin
              state_q    <= GMP_IDLE;
              tx_valid_q <= 1'b0;
              tx_last_q  <= 1'b0;
              req_done_q <= 1'b1;
            end else begin
              tx_idx_q  <= nidx;
              tx_byte_q <= rb;
              tx_last_q <= (nidx == resp_len_q - 8'h01);
            end
          end
        end
        default: begin
          state_q    <= GMP_IDLE;
          tx_valid_q <= 1'b0;
        end
      endcase
    end
  end

  assign tx_crc_feed = tx_fire && rtu_mode && (tx_idx_q < resp_len_q - CRC_LEN);

  gmp_crc16 u_rx_crc (
    .clk      (clk),
    .reset_n  (reset_n),
    .clear    (rx_end),
    .valid    (rx_take),
    .data     (rx_byte),
    .crc_q    (rx_crc_q),
    .crc_next ()
  );

  gmp_crc16 u_tx_crc (
    .clk      (clk),
    .reset_n  (reset_n),
    .clear    (accept),
    .valid    (tx_crc_feed),
    .data     (tx_byte_q),
    .crc_q    (tx_crc_q),
    .crc_next (tx_crc_next)
  );
endmodule

//--- verif/gmp_modbus_port_props.sv
// Assertion checker for the gripper Modbus status port
`timescale 1ns/1ps
module gmp_modbus_port_props #(
  parameter int REFRESH_CYCLES_P = 16
) (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              rtu_mode,
  input wire logic              session_open,
  input wire logic              rx_end,
  input wire logic              tx_ready,
  input wire logic              tx_valid_q,
  input wire logic [7:0]        tx_byte_q,
  input wire logic              tx_last_q,
  input wire gmp_pkg::gmp_cmd_s cmd_q,
  input wire logic [7:0]        target_pos_q,
  input wire logic              motion_stop_q,
  input wire logic              crc_error_q,
  input wire logic              req_done_q
);
  import gmp_pkg::*;

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_stop_closed;
    !rtu_mode && !session_open |=> motion_stop_q;
  endproperty
  a_stop_closed: assert property (p_stop_closed) else $error("motion kept on closed session");

  property p_stop_open;
    rtu_mode || session_open |=> !motion_stop_q;
  endproperty
  a_stop_open: assert property (p_stop_open) else $error("motion stopped on open session");

  property p_open_limit;
    target_pos_q >= SOFT_OPEN_LIMIT;
  endproperty
  a_open_limit: assert property (p_open_limit) else $error("target below open limit");

  property p_target_follows;
    $stable(cmd_q.pos_req) && cmd_q.pos_req >= SOFT_OPEN_LIMIT |-> target_pos_q == cmd_q.pos_req;
  endproperty
  a_target_follows: assert property (p_target_follows) else $error("target not from request");

  // Sink stall must not lose or change a byte
  property p_hold_stall;
    tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_byte_q) && $stable(tx_last_q);
  endproperty
  a_hold_stall: assert property (p_hold_stall) else $error("reply byte changed under stall");

  property p_last_done;
    tx_valid_q && tx_ready && tx_last_q |=> req_done_q && !tx_valid_q;
  endproperty
  a_last_done: assert property (p_last_done) else $error("reply did not end after last byte");

  property p_done_cause;
    req_done_q |-> $past(tx_last_q) && $past(tx_ready);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without last handshake");

  property p_crc_pulse;
    crc_error_q |-> $past(rx_end) && $past(rtu_mode) && !tx_valid_q ##1 !crc_error_q && !tx_valid_q;
  endproperty
  a_crc_pulse: assert property (p_crc_pulse) else $error("check error pulse wrong");

  property p_answer_cause;
    $rose(tx_valid_q) |-> $past(rx_end);
  endproperty
  a_answer_cause: assert property (p_answer_cause) else $error("reply not after frame end");

  property p_slave_first;
    $rose(tx_valid_q) && rtu_mode |-> tx_byte_q == RTU_SLAVE_ID;
  endproperty
  a_slave_first: assert property (p_slave_first) else $error("serial reply not led by slave id");
endmodule

//--- verif/gmp_client.sv
// Modbus client model that feeds request frames and drains replies
`timescale 1ns/1ps
module gmp_client (
  input  wire logic       clk,
  input  wire logic       tx_valid_q,
  input  wire logic [7:0] tx_byte_q,
  input  wire logic       tx_last_q,
  output logic            rx_valid,
  output logic      [7:0] rx_byte,
  output logic            rx_end,
  output logic            tx_ready
);
  // ****************************************
  // Client side
  // ****************************************
  logic [7:0] got[$];

  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h5a;
    rx_end   = 1'b0;
    tx_ready = 1'b0;
  end

  // Frames sent whole, check bytes included
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      rx_valid = 1'b1;
      rx_byte  = f[i];
      @(posedge clk);
      #1;
    end
    // Idle data inverted so no stale byte looks valid
    rx_valid = 1'b0;
    rx_byte  = ~rx_byte;
    rx_end   = 1'b1;
    @(posedge clk);
    #1;
    rx_end = 1'b0;
  endtask

  // Slow mode toggles ready to stall every other cycle
  task automatic recv(input logic slow);
    logic done;
    done = 1'b0;
    got.delete();
    for (int n = 0; n < 200; n++) begin
      tx_ready = slow ? n[0] : 1'b1;
      @(posedge clk);
      if (tx_valid_q === 1'b1 && tx_ready) begin
        got.push_back(tx_byte_q);
        done = tx_last_q;
      end
      #1;
      if (done) break;
    end
    tx_ready = 1'b0;
    @(posedge clk);
    #1;
  endtask
endmodule

//--- verif/gmp_modbus_port_test.sv
// Self-checking testbench for the gripper Modbus status port
`timescale 1ns/1ps
module gmp_modbus_port_test;
  import gmp_pkg::*;
  typedef logic [7:0] gmp_bytes_t[$];

  logic             clk;
  logic             reset_n;
  logic             rtu_mode;
  logic             session_open;
  logic             rx_valid;
  logic       [7:0] rx_byte;
  logic             rx_end;
  logic             tx_ready;
  gmp_core_status_s core_status;
  logic             tx_valid_q;
  logic       [7:0] tx_byte_q;
  logic             tx_last_q;
  gmp_cmd_s         cmd_q;
  logic       [7:0] target_pos_q;
  logic             motion_stop_q;
  logic             crc_error_q;
  logic             req_done_q;
  int               error_cnt;
  int               checks;

  // Short refresh period keeps the run brief
  gmp_modbus_port #(.REFRESH_CYCLES_P(16)) dut (
    .clk(clk), .reset_n(reset_n), .rtu_mode(rtu_mode), .session_open(session_open), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_end(rx_end), .tx_ready(tx_ready), .core_status(core_status),
    .tx_valid_q(tx_valid_q), .tx_byte_q(tx_byte_q), .tx_last_q(tx_last_q), .cmd_q(cmd_q),
    .target_pos_q(target_pos_q), .motion_stop_q(motion_stop_q), .crc_error_q(crc_error_q),
    .req_done_q(req_done_q)
  );

  gmp_client client (
    .clk(clk), .tx_valid_q(tx_valid_q), .tx_byte_q(tx_byte_q), .tx_last_q(tx_last_q),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end), .tx_ready(tx_ready)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic gmp_bytes_t hx(input string s);
    gmp_bytes_t q;
    for (int i = 0; i < s.len(); i += 2) q.push_back(8'(s.substr(i, i + 1).atohex()));
    return q;
  endfunction

  task automatic fail(input string m);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic chk_val(input logic [47:0] g, input logic [47:0] e, input string m);
    checks++;
    if (g !== e) fail(m);
  endtask

  task automatic chk_frame(input gmp_bytes_t e);
    logic bad;
    checks++;
    bad = client.got.size() != e.size();
    foreach (e[i]) if (i < client.got.size() && client.got[i] !== e[i]) bad = 1'b1;
    if (bad) fail("reply frame differs");
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic xfer(input gmp_bytes_t f, input logic slow, input gmp_bytes_t e);
    client.send(f);
    client.recv(slow);
    chk_frame(e);
  endtask

  task automatic test_done();
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_session();
    rtu_mode     = 1'b0;
    session_open = 1'b0;
    wait_cyc(2);
    chk_val(motion_stop_q, 1'b1, "closed session keeps motion");
    session_open = 1'b1;
    wait_cyc(2);
    chk_val(motion_stop_q, 1'b0, "open session stops motion");
  endtask

  task automatic t_serial_write();
    rtu_mode = 1'b1;
    xfer(hx("091003e8000306090000"), 1'b0, hx(""));
    xfer(hx("091003e800030609000000ffff7219"), 1'b1, hx("091003e800030130"));
    xfer(hx("091003e800030609000000ffff7219"), 1'b0, hx("091003e800030130"));
    chk_val(cmd_q, 48'h0900_0000_ffff, "serial write not committed");
    chk_val(target_pos_q, 8'h0d, "open request not limited");
  endtask

  task automatic t_serial_poll();
    core_status = '{1'b1, 1'b1, 2'h3, OBJ_MOVING, 8'h00, 8'hbb, 8'h10};
    wait_cyc(40);
    xfer(hx("090307d00003040e"), 1'b0, hx("09030639000000bb1030e0"));
    core_status = '{1'b1, 1'b1, 2'h3, OBJ_AT_POS, 8'h00, 8'h02, 8'h00};
    wait_cyc(40);
    xfer(hx("090307d00003040e"), 1'b1, hx("090306f90000000d00564c"));
  endtask

  task automatic t_tcp();
    rtu_mode = 1'b0;
    xfer(hx("01000000000d021000000003060900006400ff"), 1'b0, hx("010000000006021000000003"));
    chk_val(cmd_q, 48'h0900_0064_00ff, "tcp write not committed");
    chk_val(target_pos_q, 8'h64, "target position wrong");
    core_status = '{1'b1, 1'b1, 2'h3, OBJ_AT_POS, 8'h0a, 8'h80, 8'h05};
    wait_cyc(40);
    xfer(hx("010000000006020400000006"), 1'b1, hx("01000000000f02040cf9000a648005000000000000"));
    xfer(hx("453300000006020400000001"), 1'b0, hx("453300000005020402f900"));
  endtask

  task automatic t_refuse();
    xfer(hx("010000000006020300000003"), 1'b0, hx(""));
    xfer(hx("010000000006030400000003"), 1'b0, hx(""));
    xfer(hx("010000000006020400060003"), 1'b0, hx(""));
    rtu_mode = 1'b1;
    client.send(hx("090307d00003040f"));
    chk_val(crc_error_q, 1'b1, "bad check not flagged");
    client.recv(1'b0);
    chk_frame(hx(""));
    xfer(hx("091003e800030609000011ffff7219"), 1'b0, hx(""));
    chk_val(cmd_q, 48'h0900_0064_00ff, "rejected frame wrote commands");
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    error_cnt    = 0;
    checks       = 0;
    reset_n      = 1'b0;
    rtu_mode     = 1'b1;
    session_open = 1'b1;
    core_status  = '0;
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_session();
    t_serial_write();
    t_serial_poll();
    t_tcp();
    t_refuse();
    test_done();
  end

  // Whole run is under two thousand cycles
  initial begin
    #200000;
    fail("watchdog expired");
    test_done();
  end
endmodule

bind gmp_modbus_port gmp_modbus_port_props #(.REFRESH_CYCLES_P(REFRESH_CYCLES_P)) props (
  .clk(clk), .reset_n(reset_n), .rtu_mode(rtu_mode), .session_open(session_open), .rx_end(rx_end),
  .tx_ready(tx_ready), .tx_valid_q(tx_valid_q), .tx_byte_q(tx_byte_q), .tx_last_q(tx_last_q), .cmd_q(cmd_q),
  .target_pos_q(target_pos_q), .motion_stop_q(motion_stop_q), .crc_error_q(crc_error_q),
  .req_done_q(req_done_q)
);
